// file: rtl/acs_defs.svh
// Offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ACS_CLK_MHZ 250
`define ACS_T_STRB_NS 40
`define ACS_STRB_CYC ((`ACS_T_STRB_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_T_WAKE_NS 1000
`define ACS_WAKE_CYC ((`ACS_T_WAKE_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_T_ACQ_NS 1400
`define ACS_ACQ_CYC ((`ACS_T_ACQ_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_T_SAMP_NS 500
`define ACS_SAMP_CYC ((`ACS_T_SAMP_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_T_CONV_NS 3600
`define ACS_CONV_CYC ((`ACS_T_CONV_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_T_TEMP_NS 53100
`define ACS_TEMP_CYC ((`ACS_T_TEMP_NS * `ACS_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Command byte fields
// ----------------------------------------------------------------
`define ACS_CB_CONV 7
`define ACS_CB_CH_HI 6
`define ACS_CB_CH_LO 3
`define ACS_CB_TEMP 0
`define ACS_SB_TAG 2'b01
`define ACS_SB_MODE_HI 5
`define ACS_SB_MODE_LO 4
`define ACS_SB_BIP 3
`define ACS_SB_AVG_HI 2
`define ACS_SB_AVG_LO 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACS_MODE_RST 2'b10
`define ACS_PINS_RST 4'h5

`endif

// file: rtl/acs_pkg.sv
// Types shared by the conversion sequencer files
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_M_STRB = 2'b00,
    ACS_M_TRACK = 2'b01,
    ACS_M_SER = 2'b10,
    ACS_M_EXT = 2'b11
  } acs_mode_e;

  typedef enum logic [2:0] {
    ACS_IDLE, ACS_WAKE, ACS_TRACK, ACS_SAMP, ACS_CONV, ACS_TEMP, ACS_STORE
  } acs_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic strb_n;
  } acs_pins_s;

  typedef struct packed {
    acs_mode_e mode;
    logic bip;
    logic [1:0] avg;
    logic [3:0] last_ch;
    logic temp_req;
  } acs_cfg_s;

  typedef struct packed {
    acs_pins_s s1;
    acs_pins_s s2;
    acs_pins_s s3;
    acs_cfg_s cfg;
    acs_state_e st;
    logic temp_pend;
    logic tflag;
    logic [3:0] ch;
    logic [3:0] nconv;
    logic [13:0] acc;
    logic [15:0] tmr;
    logic [3:0] strb_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [15:0] tx_sh;
    logic [15:0] tx_word;
    logic [3:0] tx_cnt;
    logic tx_live;
    logic [15:0] word;
    logic dout;
    logic eoc_n;
    logic track;
    logic awake;
    logic [3:0] mux;
    logic [7:0] ext_byte;
    logic ext_valid;
  } acs_seq_s;

endpackage : acs_pkg

// file: rtl/acs_fifo.sv
// Result queue with valid/ready on both sides
module acs_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } acs_fifo_s;

  acs_fifo_s r;
  acs_fifo_s n;
  logic push;
  logic pop;

  always_comb begin
    n = r;
    in_ready_o = (r.cnt != (AW+1)'(D));
    out_valid_o = (r.cnt != '0);
    out_data_o = r.mem[r.rp];
    push = in_valid_i && in_ready_o;
    pop = out_ready_i && out_valid_o;
    if (push) begin
      n.mem[r.wp] = in_data_i;
      n.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

endmodule : acs_fifo

// file: rtl/acs_seq.sv
// Conversion sequencer, serial port and result readout
// Functional notes
// RULE_01 - Voltage code step is reference/1024; temperature code step is 0.125 C
// RULE_02 - Bipolar and temperature results two's complement; others straight binary
// RULE_03 - Select rising mid first byte drops the rest; next read gives next 8 bits
// RULE_04 - Cut second byte is dropped, queue kept; host skips 4 leading bits
// RULE_05 - Host selects the port only after end-of-conversion goes low
// RULE_06 - Write cut before eight clocks is ignored, target unchanged
// RULE_07 - Mode 00: strobe low 40 ns then high runs a whole scan
// RULE_08 - Mode 00: end-of-conversion low after scan until select or strobe falls
// RULE_09 - Requested temperature result is queued ahead of channel results, 12 bits
// RULE_10 - Host does not pulse the strobe again before end-of-conversion goes low
// RULE_11 - Other register writes are accepted while converting
// RULE_12 - Mode 01: falling strobe wakes and tracks; host holds low 1.4 us
// RULE_13 - Mode 01 with internal reference: host adds 45 us of strobe low time
// RULE_14 - Mode 01 temperature: timed internally; host holds strobe low 40 us
// RULE_15 - Mode 01: rising strobe converts, then shutdown and end-of-conversion low
// RULE_16 - Mode 01: host gives one strobe per conversion implied by scan and averaging
// RULE_17 - After the set number of averaged conversions, queue one result, step channel
// RULE_18 - Mode 01: temperature runs after first rising strobe following command byte
// RULE_19 - Powers up in mode 10; a command byte alone runs a full scan
// RULE_20 - Mode 10: end-of-conversion low after scan until select next falls
// RULE_21 - Host reads the queue only after all conversions finish
// RULE_22 - Results leave MSB first: four zeros, ten bits, two sub-bits, on falling clock
`include "acs_defs.svh"

module acs_seq #(
  parameter int TEMP_CYC = `ACS_TEMP_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic convert_strobe_n_i,
  input wire logic [9:0] adc_code_i,
  input wire logic [11:0] temp_code_i,
  output logic dout_o,
  output logic eoc_n_o,
  output logic [3:0] mux_ch_o,
  output logic track_o,
  output logic awake_o,
  output logic [7:0] ext_byte_o,
  output logic ext_valid_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] avg_last(input logic [1:0] a);
    case (a)
      2'b00: avg_last = 4'h0;
      2'b01: avg_last = 4'h3;
      2'b10: avg_last = 4'h7;
      default: avg_last = 4'hf;
    endcase
  endfunction : avg_last

  function automatic logic [15:0] fmt_word(input logic [13:0] s, input logic [1:0] a,
                                           input logic bip);
    logic [13:0] q;
    logic [9:0] c;
    q = 14'h0;
    case (a)
      2'b00: q = s;
      2'b01: q = s >> 2;
      2'b10: q = s >> 3;
      default: q = s >> 4;
    endcase
    c = q[9:0];
    if (bip) begin
      c[9] = ~c[9]; // see RULE_02
    end
    fmt_word = {4'h0, c, 2'b00}; // see RULE_22
  endfunction : fmt_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acs_pkg::acs_seq_s r;
  acs_pkg::acs_seq_s n;
  acs_pkg::acs_pins_s pins;
  logic cs_fall, cs_rise, sck_rise, sck_fall, st_fall, st_rise;
  logic conv_cmd, load_now, fin, tmr_done;
  logic [7:0] rx_byte;
  logic [13:0] sum;
  logic f_in_ready, f_out_valid, f_pop;
  logic [15:0] f_out_data;

  assign pins = '{sclk: sclk_i, cs_n: cs_n_i, din: din_i, strb_n: convert_strobe_n_i};

  always_comb begin
    n = r;
    n.ext_valid = 1'b0;
    conv_cmd = 1'b0;
    fin = 1'b0;
    f_pop = 1'b0;
    // Only the second stage and beyond feed logic
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    cs_fall = r.s3.cs_n && !r.s2.cs_n;
    cs_rise = !r.s3.cs_n && r.s2.cs_n;
    sck_rise = !r.s3.sclk && r.s2.sclk && !r.s2.cs_n;
    sck_fall = r.s3.sclk && !r.s2.sclk && !r.s2.cs_n;
    st_fall = r.s3.strb_n && !r.s2.strb_n;
    st_rise = !r.s3.strb_n && r.s2.strb_n;
    rx_byte = {r.rx_sh[6:0], r.s2.din};
    sum = r.acc + 14'(adc_code_i);
    tmr_done = (r.tmr == 16'h0);
    if (!tmr_done) begin
      n.tmr = r.tmr - 16'h1;
    end

    // Strobe low time, saturating at the least pulse width
    if (!r.s2.strb_n) begin
      if (r.strb_cnt != 4'(`ACS_STRB_CYC)) begin
        n.strb_cnt = r.strb_cnt + 4'h1;
      end
    end else begin
      n.strb_cnt = 4'h0;
    end

    // ----------------------------------------------------------------
    // Serial input
    // ----------------------------------------------------------------
    if (cs_fall || cs_rise) begin
      n.rx_cnt = 3'h0; // see RULE_06
    end
    if (sck_rise) begin
      n.rx_sh = rx_byte;
      n.rx_cnt = r.rx_cnt + 3'h1;
      if (r.rx_cnt == 3'h7) begin
        if (rx_byte[`ACS_CB_CONV]) begin
          n.cfg.last_ch = rx_byte[`ACS_CB_CH_HI:`ACS_CB_CH_LO];
          n.cfg.temp_req = rx_byte[`ACS_CB_TEMP];
          n.temp_pend = rx_byte[`ACS_CB_TEMP]; // see RULE_18
          n.ch = 4'h0;
          n.nconv = 4'h0;
          n.acc = 14'h0;
          conv_cmd = 1'b1;
        end else if (rx_byte[7:6] == `ACS_SB_TAG) begin
          n.cfg.mode = acs_pkg::acs_mode_e'(rx_byte[`ACS_SB_MODE_HI:`ACS_SB_MODE_LO]);
          n.cfg.bip = rx_byte[`ACS_SB_BIP];
          n.cfg.avg = rx_byte[`ACS_SB_AVG_HI:`ACS_SB_AVG_LO];
        end else begin
          // Passed on whatever the sequencer is doing
          n.ext_byte = rx_byte; // see RULE_11
          n.ext_valid = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    if (sck_fall) begin
      n.tx_sh = {r.tx_sh[14:0], 1'b0};
      n.tx_cnt = r.tx_cnt + 4'h1;
      n.dout = r.tx_sh[14]; // see RULE_22
    end
    if (cs_rise && r.tx_live) begin
      if (r.tx_cnt != 4'h0 && r.tx_cnt < 4'h8) begin
        n.tx_sh = {r.tx_word[7:0], 8'h00}; // see RULE_03
        n.tx_cnt = 4'h8;
        n.dout = r.tx_word[7];
      end else if (r.tx_cnt > 4'h8) begin
        n.tx_live = 1'b0; // see RULE_04
        n.dout = 1'b0;
      end
    end
    load_now = (cs_fall && !r.tx_live) || (sck_fall && r.tx_live && r.tx_cnt == 4'hf);
    if (load_now) begin
      f_pop = f_out_valid;
      n.tx_live = f_out_valid;
      n.tx_sh = f_out_valid ? f_out_data : 16'h0;
      n.tx_word = n.tx_sh;
      n.tx_cnt = 4'h0;
      n.dout = n.tx_sh[15];
    end

    // ----------------------------------------------------------------
    // End-of-conversion release
    // ----------------------------------------------------------------
    if (cs_fall || (st_fall && r.cfg.mode != acs_pkg::ACS_M_SER)) begin
      n.eoc_n = 1'b1; // see RULE_08 RULE_20
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    case (r.st)
      acs_pkg::ACS_IDLE: begin
        if ((r.cfg.mode == acs_pkg::ACS_M_SER && conv_cmd) ||
            (r.cfg.mode == acs_pkg::ACS_M_STRB && st_rise &&
             r.strb_cnt == 4'(`ACS_STRB_CYC))) begin
          n.st = acs_pkg::ACS_WAKE; // see RULE_07 RULE_19
          n.tmr = 16'(`ACS_WAKE_CYC);
          n.awake = 1'b1;
          n.ch = 4'h0;
          n.nconv = 4'h0;
          n.acc = 14'h0;
          n.mux = 4'h0;
          n.temp_pend = n.cfg.temp_req;
        end else if (r.cfg.mode == acs_pkg::ACS_M_TRACK && st_fall) begin
          n.st = acs_pkg::ACS_TRACK; // see RULE_12
          n.awake = 1'b1;
          n.track = 1'b1;
          n.mux = r.ch;
        end
      end
      acs_pkg::ACS_WAKE: begin
        if (tmr_done) begin
          if (r.temp_pend) begin
            n.st = acs_pkg::ACS_TEMP;
            n.tmr = 16'(TEMP_CYC);
          end else begin
            n.st = acs_pkg::ACS_TRACK;
            n.tmr = 16'(`ACS_ACQ_CYC);
            n.track = 1'b1;
          end
        end
      end
      acs_pkg::ACS_TRACK: begin
        // Mode 01 acquires for as long as the host holds the strobe low
        if (r.cfg.mode == acs_pkg::ACS_M_TRACK ? st_rise : tmr_done) begin
          if (r.temp_pend) begin
            n.st = acs_pkg::ACS_TEMP; // see RULE_18
            n.tmr = 16'(TEMP_CYC); // see RULE_14
            n.track = 1'b0;
          end else begin
            n.st = acs_pkg::ACS_SAMP; // see RULE_15
            n.tmr = 16'(`ACS_SAMP_CYC);
          end
        end
      end
      acs_pkg::ACS_TEMP: begin
        if (tmr_done) begin
          n.word = {4'h0, temp_code_i}; // see RULE_01 RULE_02 RULE_09
          n.temp_pend = 1'b0;
          n.tflag = 1'b1;
          n.st = acs_pkg::ACS_STORE;
        end
      end
      acs_pkg::ACS_SAMP: begin
        n.track = 1'b1;
        if (tmr_done) begin
          n.track = 1'b0;
          n.st = acs_pkg::ACS_CONV;
          n.tmr = 16'(`ACS_CONV_CYC);
        end
      end
      acs_pkg::ACS_CONV: begin
        if (tmr_done) begin
          if (r.nconv == avg_last(r.cfg.avg)) begin
            n.word = fmt_word(sum, r.cfg.avg, r.cfg.bip); // see RULE_01 RULE_17
            n.acc = 14'h0;
            n.nconv = 4'h0;
            n.st = acs_pkg::ACS_STORE;
          end else begin
            n.acc = sum;
            n.nconv = r.nconv + 4'h1;
            if (r.cfg.mode == acs_pkg::ACS_M_TRACK) begin
              fin = 1'b1; // see RULE_15
            end else begin
              n.st = acs_pkg::ACS_TRACK;
              n.tmr = 16'(`ACS_ACQ_CYC);
              n.track = 1'b1;
            end
          end
        end
      end
      acs_pkg::ACS_STORE: begin
        // A full queue stalls the scan here until the host reads
        if (f_in_ready) begin
          n.tflag = 1'b0;
          if (r.tflag) begin
            n.st = (r.cfg.mode == acs_pkg::ACS_M_TRACK) ? acs_pkg::ACS_SAMP : acs_pkg::ACS_TRACK;
            n.tmr = (r.cfg.mode == acs_pkg::ACS_M_TRACK) ? 16'(`ACS_SAMP_CYC) : 16'(`ACS_ACQ_CYC);
            n.track = 1'b1;
          end else begin
            n.ch = (r.ch == r.cfg.last_ch) ? 4'h0 : r.ch + 4'h1; // see RULE_17
            n.mux = n.ch;
            if (r.cfg.mode == acs_pkg::ACS_M_TRACK || r.ch == r.cfg.last_ch) begin
              fin = 1'b1;
            end else begin
              n.st = acs_pkg::ACS_TRACK;
              n.tmr = 16'(`ACS_ACQ_CYC);
              n.track = 1'b1;
            end
          end
        end
      end
      default: begin
        n.st = acs_pkg::ACS_IDLE;
      end
    endcase
    if (fin) begin
      // Set wins over a release in the same cycle
      n.st = acs_pkg::ACS_IDLE;
      n.eoc_n = 1'b0; // see RULE_08 RULE_15 RULE_20
      n.awake = 1'b0;
      n.track = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.s1 <= `ACS_PINS_RST;
      r.s2 <= `ACS_PINS_RST;
      r.s3 <= `ACS_PINS_RST;
      r.cfg.mode <= acs_pkg::acs_mode_e'(`ACS_MODE_RST); // see RULE_19
      r.eoc_n <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  acs_fifo #(.W(16), .D(4)) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_valid_i(r.st == acs_pkg::ACS_STORE),
    .in_ready_o(f_in_ready),
    .in_data_i(r.word),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_out_data)
  );

  assign dout_o = r.dout;
  assign eoc_n_o = r.eoc_n;
  assign mux_ch_o = r.mux;
  assign track_o = r.track;
  assign awake_o = r.awake;
  assign ext_byte_o = r.ext_byte;
  assign ext_valid_o = r.ext_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_short_strobe: assert property (r.cfg.mode == acs_pkg::ACS_M_STRB && st_rise // see RULE_07
    && r.st == acs_pkg::ACS_IDLE && r.strb_cnt < 4'(`ACS_STRB_CYC)
    |=> r.st == acs_pkg::ACS_IDLE && !awake_o)
    else $error("short strobe started a scan");
  a_strobe_scan: assert property (r.cfg.mode == acs_pkg::ACS_M_STRB && st_rise // see RULE_07
    && r.st == acs_pkg::ACS_IDLE && r.strb_cnt == 4'(`ACS_STRB_CYC) |=> awake_o ##1 awake_o)
    else $error("valid strobe did not start a scan");
  a_eoc_release: assert property (cs_fall && !fin |=> eoc_n_o) // see RULE_08
    else $error("select fall did not release end-of-conversion");
  a_eoc_ser_hold: assert property (!eoc_n_o && !cs_fall && !fin ##0
    (r.cfg.mode == acs_pkg::ACS_M_SER || !st_fall) |=> !eoc_n_o) // see RULE_20
    else $error("end-of-conversion released without cause");
  a_eoc_finish: assert property (fin |=> !eoc_n_o && !awake_o && !track_o) // see RULE_15
    else $error("finish did not signal end-of-conversion");
  a_part_write: assert property (cs_rise && r.rx_cnt != 3'h0 // see RULE_06
    |=> !ext_valid_o && $stable(r.cfg))
    else $error("partial write took effect");
  a_part_first: assert property (cs_rise && r.tx_live // see RULE_03
    && r.tx_cnt inside {[4'h1:4'h7]} |=> r.tx_cnt == 4'h8 && dout_o == $past(r.tx_word[7]))
    else $error("partial first byte not skipped");
  a_part_second: assert property (cs_rise && r.tx_live && r.tx_cnt > 4'h8 // see RULE_04
    |=> !r.tx_live)
    else $error("partial second byte not dropped");
  a_word_format: assert property (r.st == acs_pkg::ACS_STORE // see RULE_22
    |-> r.word[15:12] == 4'h0)
    else $error("queued word lacks leading zeros");
  a_temp_first: assert property (r.st == acs_pkg::ACS_STORE && r.tflag // see RULE_09
    |-> r.ch == 4'h0 && r.nconv == 4'h0)
    else $error("temperature not ahead of channels");
  a_track_wake: assert property (r.cfg.mode == acs_pkg::ACS_M_TRACK && st_fall // see RULE_12
    && r.st == acs_pkg::ACS_IDLE |=> track_o && awake_o)
    else $error("strobe fall did not start tracking");
  a_mux_step: assert property (r.st == acs_pkg::ACS_STORE && f_in_ready && !r.tflag // see RULE_17
    && r.ch != r.cfg.last_ch |=> mux_ch_o == $past(r.ch) + 4'h1)
    else $error("channel not stepped after result");

  c_scan_done: cover property (r.cfg.mode == acs_pkg::ACS_M_STRB && fin);
  c_track_temp: cover property (r.cfg.mode == acs_pkg::ACS_M_TRACK && r.st == acs_pkg::ACS_TEMP);
  c_part_read: cover property (cs_rise && r.tx_live && r.tx_cnt == 4'h3);
  c_queue_full: cover property (r.st == acs_pkg::ACS_STORE && !f_in_ready);

endmodule : acs_seq

// file: tb/acs_host.sv
// Host model: drives the serial port and the convert strobe of the sequencer
module acs_host (
  input wire logic clock_i,
  input wire logic dout_i,
  input wire logic eoc_n_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic strobe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    strobe_n_o = 1'b1;
  end

  // ------------------------------------------------------------
  // Serial frame and strobe tasks
  // ------------------------------------------------------------
  // Halves of 16 ns give the 32 ns link rate; data is taken late in the
  // high phase because the device answers a few clocks after each fall
  task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clock_i) #1;
    cs_n_o = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      din_o = tx[15-i];
      #16 sclk_o = 1'b1;
      #16 rx = {rx[14:0], dout_i};
      sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    din_o = ~din_o;
    #48;
  endtask : frame

  task automatic pulse(input int low_ns);
    @(posedge clock_i) #1;
    strobe_n_o = 1'b0;
    #(low_ns);
    strobe_n_o = 1'b1;
    #48;
  endtask : pulse

  // Bounded wait so a stuck end-of-conversion cannot hang the host
  task automatic wait_eoc(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 20000 && !ok; i++) begin
      @(posedge clock_i);
      ok = (eoc_n_i === 1'b0);
    end
  endtask : wait_eoc
endmodule : acs_host

// file: tb/adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer against a queue model
module adc_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i;
  logic rst_n_i;
  logic sclk, cs_n, din, strobe_n, dout, eoc_n, track, awake, ext_valid;
  logic [3:0] mux_ch;
  logic [7:0] ext_byte;
  logic [9:0] adc_code = 10'h000;
  logic [11:0] temp_code = 12'h000;
  logic [7:0] ext_seen = 8'h00;
  logic [15:0] exp_q[$];
  logic [15:0] e[4];
  logic [15:0] rx;
  logic ce = 1'b1;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ext_cnt = 0;
  int unsigned seed;
  bit ok;

  acs_seq #(.TEMP_CYC(50)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .convert_strobe_n_i(strobe_n),
    .adc_code_i(adc_code), .temp_code_i(temp_code), .dout_o(dout), .eoc_n_o(eoc_n),
    .mux_ch_o(mux_ch), .track_o(track), .awake_o(awake), .ext_byte_o(ext_byte),
    .ext_valid_o(ext_valid));
  acs_host u_host (.clock_i(clock_i), .dout_i(dout), .eoc_n_i(eoc_n), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din), .strobe_n_o(strobe_n));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Ceiling is about twice the expected run length
  always @(posedge clock_i) begin
    cyc++;
    if (ext_valid === 1'b1) begin
      ext_cnt++;
      ext_seen = ext_byte;
    end
    if (cyc == 70000) begin
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [15:0] ch_entry(input logic [9:0] c, input bit bip);
    return {4'h0, bip ? (c ^ 10'h200) : c, 2'b00};
  endfunction : ch_entry

  task automatic wr(input logic [7:0] b);
    u_host.frame(8, {b, 8'h00}, rx);
  endtask : wr

  task automatic read_all(input string what);
    while (exp_q.size() > 0) begin
      u_host.frame(16, 16'h0000, rx);
      chk(rx, exp_q.pop_front(), what);
    end
  endtask : read_all

  task automatic fill_scan(input bit bip, input int nch);
    @(posedge clock_i) #1;
    adc_code = 10'($urandom);
    temp_code = 12'($urandom);
    exp_q.push_back({4'h0, temp_code});
    for (int c = 0; c < nch; c++) begin
      exp_q.push_back(ch_entry(adc_code, bip));
    end
  endtask : fill_scan

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(32'h6947c399);
    rst_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk({14'h0, eoc_n, awake}, 16'h0002, "reset outputs");
    // Power-up mode: a conversion byte alone runs the scan, temperature first
    fill_scan(1'b0, 3);
    wr(8'h91);
    repeat (150) @(posedge clock_i);
    chk({15'h0, awake}, 16'h0001, "awake in scan");
    wr(8'h2a);
    u_host.frame(5, 16'hc000, rx);
    u_host.wait_eoc(ok);
    chk({15'h0, ok}, 16'h0001, "mode 10 done");
    chk({15'h0, awake}, 16'h0000, "shut down");
    chk({ext_cnt[7:0], ext_seen}, 16'h012a, "other byte");
    read_all("mode 10 entry");
    chk({15'h0, eoc_n}, 16'h0001, "eoc after select");
    // Strobe mode, bipolar: scan with the last conversion byte, partial reads
    wr(8'h48);
    fill_scan(1'b1, 3);
    u_host.pulse(60);
    u_host.wait_eoc(ok);
    chk({15'h0, ok}, 16'h0001, "mode 00 done");
    // A strobe while the enable is low must be missed entirely
    #1 ce = 1'b0;
    u_host.pulse(12);
    ce = 1'b1;
    repeat (6) @(posedge clock_i);
    chk({15'h0, eoc_n}, 16'h0000, "frozen by enable");
    u_host.pulse(12);
    chk({15'h0, eoc_n}, 16'h0001, "eoc after strobe");
    for (int i = 0; i < 4; i++) begin
      e[i] = exp_q.pop_front();
    end
    u_host.frame(5, 16'h0000, rx);
    chk({11'h0, rx[4:0]}, {11'h0, e[0][15:11]}, "cut first byte");
    u_host.frame(8, 16'h0000, rx);
    chk({8'h0, rx[7:0]}, {8'h0, e[0][7:0]}, "rest of entry");
    u_host.frame(16, 16'h0000, rx);
    chk(rx, e[1], "whole entry");
    u_host.frame(12, 16'h0000, rx);
    chk({4'h0, rx[11:0]}, {4'h0, e[2][15:4]}, "cut second byte");
    u_host.frame(16, 16'h0000, rx);
    chk(rx, e[3], "entry after cut");
    // Track mode, averaging of four: one strobe per conversion
    wr(8'h52);
    wr(8'h88);
    for (int ch = 0; ch < 2; ch++) begin
      @(posedge clock_i) #1;
      adc_code = 10'($urandom);
      exp_q.push_back(ch_entry(adc_code, 1'b0));
      for (int k = 0; k < 4; k++) begin
        fork
          // External reference only, so no reference power-up time is owed
          u_host.pulse(1500);
          begin
            repeat (100) @(posedge clock_i);
            chk({14'h0, track, awake}, 16'h0003, "tracking");
          end
        join
        u_host.wait_eoc(ok);
        chk({15'h0, ok}, 16'h0001, "mode 01 done");
        if (ch == 0) begin
          chk({12'h0, mux_ch}, (k == 3) ? 16'h0001 : 16'h0000, "channel step");
        end
      end
    end
    read_all("averaged entry");
    // Track mode with temperature: one long strobe gives temperature, then channel 0
    wr(8'h50);
    wr(8'h81);
    fill_scan(1'b0, 1);
    u_host.pulse(40000);
    u_host.wait_eoc(ok);
    chk({15'h0, ok}, 16'h0001, "mode 01 temp done");
    read_all("track temperature");
    close_out();
  end
endmodule : adc_conversion_sequencer_bench
